/* File: inc/flc_defs.svh */
// Offsets, field positions and timing counts of the flash mode controller.
// Assumes a 10 MHz reference clock; included by the package and design modules.
`ifndef FLC_DEFS_SVH
`define FLC_DEFS_SVH

`define FLC_CLK_NS 100
`define FLC_RAMP_STEP_NS 8000
`define FLC_RAMP_CYC (`FLC_RAMP_STEP_NS / `FLC_CLK_NS)
`define FLC_PWM_HZ 31500
`define FLC_PWM_CYC (1000000000 / (`FLC_PWM_HZ * `FLC_CLK_NS))
`define FLC_IDLE_MS 100
`define FLC_IDLE_CYC (`FLC_IDLE_MS * 1000000 / `FLC_CLK_NS)
`define FLC_FTO_STEP_US 2000
`define FLC_FTO_CYC (`FLC_FTO_STEP_US * 1000 / `FLC_CLK_NS)
`define FLC_NPINS 7

`define FLC_ADDR_CUR1 4'h0
`define FLC_ADDR_CUR2 4'h1
`define FLC_ADDR_TXM 4'h2
`define FLC_ADDR_LOWV 4'h3
`define FLC_ADDR_FTO 4'h4
`define FLC_ADDR_CTRL 4'h5
`define FLC_ADDR_PWM 4'h6
`define FLC_ADDR_FAULT 4'h7
`define FLC_ADDR_ACTUAL 4'h8
`define FLC_ADDR_MIN 4'h9
`define FLC_ADDR_STATUS 4'hA

`define FLC_LOWV_SD_BIT 0
`define FLC_LOWV_BAL_BIT 1
`define FLC_CTRL_MODE_LSB 0
`define FLC_CTRL_TORCH_LSB 2
`define FLC_CTRL_OUT_BIT 4
`define FLC_CTRL_STRB_BIT 5
`define FLC_CTRL_STYPE_BIT 6

`define FLC_MODE_OFF 2'h0
`define FLC_MODE_IND 2'h1
`define FLC_MODE_ASSIST 2'h2
`define FLC_MODE_FLASH 2'h3
`define FLC_EXT_TXMASK 2'h1
`define FLC_EXT_TORCH 2'h2
`define FLC_CAP7 8'h7F
`define FLC_CAP6 8'h3F
`define FLC_BAL_MUL 16'h0019

`endif

/* File: inc/flc_pkg.sv */
// Types shared by the flash mode controller modules.
// Assumes flc_defs.svh is on the include path.
`include "flc_defs.svh"
package flc_pkg;
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b000,
      ST_TORCH = 3'b001,
      ST_IND = 3'b010,
      ST_ASSIST = 3'b011,
      ST_FL_WAIT = 3'b100,
      ST_FLASH = 3'b101,
      ST_FL_DONE = 3'b110
   } flc_mode_t;

   typedef struct packed {
      logic scl;
      logic torch;
      logic strobe;
      logic vlow;
      logic vrun;
      logic bal_up;
      logic bal_dn;
   } flc_pins_t;

   typedef struct packed {
      logic [7:0] cur1;
      logic [7:0] cur2;
      logic [7:0] txm_cur;
      logic [7:0] fto;
      logic load_bal;
      logic lowv_sd;
      logic strobe_type;
      logic strobe_on;
      logic out_on;
      logic [1:0] ext_torch;
      logic [1:0] mode_sel;
      logic [3:0] duty;
      logic flt_txm;
      logic flt_uv;
      logic flt_to;
      logic [7:0] actual;
      logic [7:0] min_cur;
   } flc_regs_t;
endpackage : flc_pkg

/* File: hw/flc_pin_sync.sv */
// Three-stage synchroniser for the asynchronous pins of the flash controller.
// Assumes all inputs are foreign to i_ref_clk; output is a clean level.
`timescale 1ns/1ps
`include "flc_defs.svh"
module flc_pin_sync (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire flc_pkg::flc_pins_t i_pins,
   output flc_pkg::flc_pins_t o_pins
);
   import flc_pkg::*;

   typedef struct packed {
      logic [`FLC_NPINS-1:0] s1;
      logic [`FLC_NPINS-1:0] s2;
      logic [`FLC_NPINS-1:0] s3;
      logic [`FLC_NPINS-1:0] q;
   } flc_sync_t;

   flc_sync_t s_reg;
   flc_sync_t s_next;
   logic [`FLC_NPINS-1:0] q_next;

   // A change counts only once the second and third stage agree
   genvar gi;
   generate
      for (gi = 0; gi < `FLC_NPINS; gi++) begin : g_bit
         assign q_next[gi] = (s_reg.s2[gi] == s_reg.s3[gi]) ? s_reg.s3[gi] : s_reg.q[gi];
      end
   endgenerate

   always_comb begin
      s_next = s_reg;
      s_next.s1 = i_pins;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      s_next.q = q_next;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_pins = s_reg.q;
endmodule : flc_pin_sync

/* File: hw/flc_tick_gen.sv */
// Rate dividers: 8 us ramp step, flash timeout unit and 31.5 kHz PWM gate.
// Assumes the 10 MHz reference clock; outputs are one-cycle enables or a level.
`timescale 1ns/1ps
`include "flc_defs.svh"
module flc_tick_gen #(
   parameter int unsigned FTO_CYC = `FLC_FTO_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_duty,
   output logic o_tick_ramp,
   output logic o_tick_fto,
   output logic o_pwm_on
);
   import flc_pkg::*;

   typedef struct packed {
      logic [6:0] ramp_cnt;
      logic [15:0] fto_cnt;
      logic [8:0] pwm_cnt;
      logic tick_ramp;
      logic tick_fto;
      logic pwm_on;
   } flc_tick_t;

   flc_tick_t t_reg;
   flc_tick_t t_next;
   logic [13:0] duty_thr;

   always_comb begin
      t_next = t_reg;
      duty_thr = 14'((14'(i_duty) + 14'h0001) * 14'(`FLC_PWM_CYC));
      t_next.tick_ramp = (t_reg.ramp_cnt == 7'(`FLC_RAMP_CYC - 1));
      t_next.ramp_cnt = t_next.tick_ramp ? 7'h00 : t_reg.ramp_cnt + 7'h01;
      t_next.tick_fto = (t_reg.fto_cnt == 16'(FTO_CYC - 1));
      t_next.fto_cnt = t_next.tick_fto ? 16'h0000 : t_reg.fto_cnt + 16'h0001;
      t_next.pwm_cnt = (t_reg.pwm_cnt == 9'(`FLC_PWM_CYC - 1)) ? 9'h000 : t_reg.pwm_cnt + 9'h001;
      // Duty is (n+1)/16 of the PWM period
      t_next.pwm_on = ({1'b0, t_reg.pwm_cnt, 4'h0} < duty_thr);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign o_tick_ramp = t_reg.tick_ramp;
   assign o_tick_fto = t_reg.tick_fto;
   assign o_pwm_on = t_reg.pwm_on;
endmodule : flc_tick_gen

/* File: hw/flc_mode_ctrl.sv */
// Mode and current control of a two-sink LED flash driver.
// Assumes analog comparators for battery level, and a host on a plain register port.
// Notes on behaviour
// - Clock line low for idle interval in active mode resets all registers, no current.
// - Standby with zero current when disabled and no external torch request.
// - Mode 00, torch config 10, torch pin high gives external torch mode.
// - Assist and torch use only bits 6..0 of each current setting.
// - Indicator uses bits 5..0, gated by 31.5 kHz PWM with programmed duty.
// - Flash starts at once, or on rising strobe (edge type) or high strobe (level type); timeout register sets duration.
// - Level strobe flash drives current only while strobe pin is high.
// - Level strobe flash ends when timeout expires even with strobe high.
// - Mask config 01 and mask pin high lower flash to mask current.
// - Low battery before flash suppresses or reduces it and flags undervoltage.
// - Low battery during flash steps current down or halts ramp, flags undervoltage.
// - Low battery reduction moves one current step every 8 us.
// - Applied flash current is readable while the flash runs.
// - Lowest current reached during a flash stays readable afterwards.
// - Load balancing may shift each sink current by up to ten percent.
// - Reading the fault register clears all fault bits.
// - Timer runs with each flash; overlong flash is stopped, and flagged unless it is an edge strobe flash.
// - Mask pin high during flash with mask reduction on sets mask fault.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "flc_defs.svh"
module flc_mode_ctrl #(
   parameter int unsigned IDLE_CYC = `FLC_IDLE_CYC,
   parameter int unsigned FTO_CYC = `FLC_FTO_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_scl,
   input wire logic i_torch,
   input wire logic i_strobe,
   input wire logic i_vin_below_low,
   input wire logic i_vin_below_run,
   input wire logic i_bal_up,
   input wire logic i_bal_down,
   output logic [7:0] o_sink1_code,
   output logic [7:0] o_sink2_code,
   output logic o_sink_en,
   output flc_pkg::flc_mode_t o_mode
);
   import flc_pkg::*;

   typedef struct packed {
      flc_regs_t r;
      flc_mode_t st;
      logic ramping;
      logic use_txm;
      logic [8:0] tmr;
      logic [19:0] idle;
      logic strb_prev;
      logic [7:0] rdata;
      logic [7:0] sink1;
      logic [7:0] sink2;
      logic sink_en;
   } flc_state_t;

   localparam logic [19:0] IDLE_LAST = 20'(IDLE_CYC - 1);

   flc_state_t s;
   flc_state_t n;
   flc_pins_t p;
   logic tick_ramp;
   logic tick_fto;
   logic pwm_on;
   logic active;
   logic idle_fire;
   logic flash_sel;
   logic torch_on;
   logic txm_act;
   logic expired;
   logic go;
   logic [7:0] tgt;
   logic [7:0] set_max;

   flc_pin_sync u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_pins({i_scl, i_torch, i_strobe, i_vin_below_low, i_vin_below_run, i_bal_up,
               i_bal_down}),
      .o_pins(p)
   );

   flc_tick_gen #(.FTO_CYC(FTO_CYC)) u_tick (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_duty(s.r.duty),
      .o_tick_ramp(tick_ramp),
      .o_tick_fto(tick_fto),
      .o_pwm_on(pwm_on)
   );

   // Trim of about 9.8 percent toward or away from a sink
   function automatic logic [7:0] bal_trim(input logic [7:0] code, input logic up,
                                           input logic dn);
      logic [15:0] trim;
      logic [8:0] sum;
      trim = (16'(code) * `FLC_BAL_MUL) >> 8;
      sum = {1'b0, code};
      if (up) begin
         sum = sum + 9'(trim);
      end else if (dn) begin
         sum = sum - 9'(trim);
      end
      bal_trim = sum[8] ? 8'hFF : sum[7:0];
   endfunction : bal_trim

   assign active = s.r.out_on && (s.r.mode_sel != `FLC_MODE_OFF);
   assign idle_fire = active && !p.scl && (s.idle == IDLE_LAST);
   assign flash_sel = s.r.out_on && (s.r.mode_sel == `FLC_MODE_FLASH);
   assign torch_on = (s.r.mode_sel == `FLC_MODE_OFF) && (s.r.ext_torch == `FLC_EXT_TORCH)
                     && p.torch;
   assign txm_act = (s.r.ext_torch == `FLC_EXT_TXMASK) && p.torch;
   assign expired = (s.tmr > {1'b0, s.r.fto});
   assign set_max = (s.r.cur1 > s.r.cur2) ? s.r.cur1 : s.r.cur2;

   always_comb begin
      n = s;
      go = 1'b0;
      tgt = (s.use_txm || txm_act) ? s.r.txm_cur : set_max;
      n.strb_prev = p.strobe;
      n.rdata = 8'h00;

      if (i_rd) begin
         case (i_addr)
            `FLC_ADDR_CUR1: n.rdata = s.r.cur1;
            `FLC_ADDR_CUR2: n.rdata = s.r.cur2;
            `FLC_ADDR_TXM: n.rdata = s.r.txm_cur;
            `FLC_ADDR_LOWV: n.rdata = {6'h00, s.r.load_bal, s.r.lowv_sd};
            `FLC_ADDR_FTO: n.rdata = s.r.fto;
            `FLC_ADDR_CTRL: n.rdata = {1'b0, s.r.strobe_type, s.r.strobe_on, s.r.out_on,
                                       s.r.ext_torch, s.r.mode_sel};
            `FLC_ADDR_PWM: n.rdata = {4'h0, s.r.duty};
            `FLC_ADDR_FAULT: begin
               n.rdata = {5'h00, s.r.flt_txm, s.r.flt_uv, s.r.flt_to};
               n.r.flt_txm = 1'b0;
               n.r.flt_uv = 1'b0;
               n.r.flt_to = 1'b0;
            end
            `FLC_ADDR_ACTUAL: n.rdata = s.r.actual;
            `FLC_ADDR_MIN: n.rdata = s.r.min_cur;
            `FLC_ADDR_STATUS: n.rdata = {5'h00, s.st};
            default: n.rdata = 8'h00;
         endcase
      end

      if (i_wr) begin
         case (i_addr)
            `FLC_ADDR_CUR1: n.r.cur1 = i_wdata;
            `FLC_ADDR_CUR2: n.r.cur2 = i_wdata;
            `FLC_ADDR_TXM: n.r.txm_cur = i_wdata;
            `FLC_ADDR_LOWV: begin
               n.r.lowv_sd = i_wdata[`FLC_LOWV_SD_BIT];
               n.r.load_bal = i_wdata[`FLC_LOWV_BAL_BIT];
            end
            `FLC_ADDR_FTO: n.r.fto = i_wdata;
            `FLC_ADDR_CTRL: begin
               n.r.mode_sel = i_wdata[`FLC_CTRL_MODE_LSB +: 2];
               n.r.ext_torch = i_wdata[`FLC_CTRL_TORCH_LSB +: 2];
               n.r.out_on = i_wdata[`FLC_CTRL_OUT_BIT];
               n.r.strobe_on = i_wdata[`FLC_CTRL_STRB_BIT];
               n.r.strobe_type = i_wdata[`FLC_CTRL_STYPE_BIT];
            end
            `FLC_ADDR_PWM: n.r.duty = i_wdata[3:0];
            default: ;
         endcase
      end

      // Mode selection; flash states hold until flash mode is left
      if (!flash_sel) begin
         if (torch_on) begin
            n.st = ST_TORCH;
         end else if (s.r.out_on && s.r.mode_sel == `FLC_MODE_IND) begin
            n.st = ST_IND;
         end else if (s.r.out_on && s.r.mode_sel == `FLC_MODE_ASSIST) begin
            n.st = ST_ASSIST;
         end else begin
            n.st = ST_STANDBY;
         end
      end else begin
         case (s.st)
            ST_FL_WAIT: begin
               go = s.r.strobe_type ? p.strobe : (p.strobe && !s.strb_prev);
            end
            ST_FLASH: begin
               if (expired) begin
                  n.st = ST_FL_DONE;
                  n.r.out_on = 1'b0;
                  n.r.mode_sel = `FLC_MODE_OFF;
                  n.r.ext_torch = 2'h0;
                  if (!s.r.strobe_on || s.r.strobe_type) begin
                     n.r.flt_to = 1'b1;
                  end
               end else if (s.r.strobe_on && s.r.strobe_type && !p.strobe) begin
                  n.st = ST_FL_WAIT;
               end
            end
            ST_FL_DONE: ;
            default: begin
               if (s.r.strobe_on) begin
                  n.st = ST_FL_WAIT;
               end else begin
                  go = 1'b1;
               end
            end
         endcase
      end

      if (go) begin
         n.st = ST_FLASH;
         n.tmr = 9'h000;
         n.ramping = 1'b1;
         n.use_txm = 1'b0;
         n.r.actual = 8'h00;
         n.r.min_cur = 8'hFF;
         if (p.vlow) begin
            n.r.flt_uv = 1'b1;
            if (s.r.lowv_sd) begin
               n.st = ST_FL_DONE;
            end else begin
               n.use_txm = 1'b1;
            end
         end
      end

      if (s.st == ST_FLASH) begin
         if (txm_act) begin
            n.r.flt_txm = 1'b1;
         end
         if (p.vrun) begin
            n.r.flt_uv = 1'b1;
         end
         if (tick_fto && !expired) begin
            n.tmr = s.tmr + 9'h001;
         end
         if (s.r.actual > tgt) begin
            n.r.actual = tgt;
         end else if (tick_ramp) begin
            if (p.vrun) begin
               if (s.ramping) begin
                  n.ramping = 1'b0;
               end else if (s.r.actual != 8'h00) begin
                  n.r.actual = s.r.actual - 8'h01;
               end
            end else if (s.ramping) begin
               if (s.r.actual < tgt) begin
                  n.r.actual = s.r.actual + 8'h01;
               end else begin
                  n.ramping = 1'b0;
               end
            end
         end
         // Lowest settled level, also taken when the flash ends mid-ramp
         if ((!s.ramping || n.st != ST_FLASH) && s.r.actual < s.r.min_cur) begin
            n.r.min_cur = s.r.actual;
         end
      end

      if (!active || p.scl) begin
         n.idle = 20'h00000;
      end else if (s.idle != IDLE_LAST) begin
         n.idle = s.idle + 20'h00001;
      end
      if (idle_fire) begin
         n = '0;
      end

      unique case (n.st)
         ST_TORCH, ST_ASSIST: begin
            n.sink1 = n.r.cur1 & `FLC_CAP7;
            n.sink2 = n.r.cur2 & `FLC_CAP7;
            n.sink_en = 1'b1;
         end
         ST_IND: begin
            n.sink1 = n.r.cur1 & `FLC_CAP6;
            n.sink2 = n.r.cur2 & `FLC_CAP6;
            n.sink_en = pwm_on;
         end
         ST_FLASH: begin
            n.sink1 = (n.r.cur1 < n.r.actual) ? n.r.cur1 : n.r.actual;
            n.sink2 = (n.r.cur2 < n.r.actual) ? n.r.cur2 : n.r.actual;
            n.sink_en = 1'b1;
         end
         default: begin
            n.sink1 = 8'h00;
            n.sink2 = 8'h00;
            n.sink_en = 1'b0;
         end
      endcase
      if (n.r.load_bal && n.sink_en) begin
         n.sink1 = bal_trim(n.sink1, p.bal_up, p.bal_dn);
         n.sink2 = bal_trim(n.sink2, p.bal_dn, p.bal_up);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign o_rdata = s.rdata;
   assign o_sink1_code = s.sink1;
   assign o_sink2_code = s.sink2;
   assign o_sink_en = s.sink_en;
   assign o_mode = s.st;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   sequence lvl_flash;
      s.st == ST_FLASH && s.r.strobe_on && s.r.strobe_type;
   endsequence

   sequence flash_steady;
      s.st == ST_FLASH && !idle_fire;
   endsequence

   chk_idle_shutdown: assert property (idle_fire |=> !s.r.out_on && s.r.mode_sel == 2'h0
      && !s.sink_en) else $error("idle shutdown did not clear");
   chk_standby_dark: assert property (s.st == ST_STANDBY |-> !s.sink_en
      && s.sink1 == 8'h00 && s.sink2 == 8'h00) else $error("current in standby");
   chk_torch_entry: assert property ((s.r.mode_sel == 2'h0 && s.r.ext_torch == 2'h2
      && p.torch) |=> s.st == ST_TORCH) else $error("torch mode not entered");
   chk_assist_cap: assert property (((s.st == ST_TORCH || s.st == ST_ASSIST)
      && !s.r.load_bal) |-> !s.sink1[7] && !s.sink2[7]) else $error("assist cap broken");
   chk_ind_cap: assert property ((s.st == ST_IND && !s.r.load_bal)
      |-> s.sink1[7:6] == 2'h0 && s.sink2[7:6] == 2'h0) else $error("indicator cap broken");
   chk_level_strobe: assert property ((lvl_flash ##0 !p.strobe)
      |=> s.st != ST_FLASH) else $error("flash outlived strobe");
   chk_ramp_tick: assert property ((s.st == ST_FLASH && $past(s.st) == ST_FLASH
      && s.r.actual == $past(s.r.actual) + 8'h01) |-> $past(tick_ramp))
      else $error("ramp step off tick");
   chk_fault_readclr: assert property ((i_rd && i_addr == `FLC_ADDR_FAULT)
      |=> o_rdata[2:0] == $past({s.r.flt_txm, s.r.flt_uv, s.r.flt_to}))
      else $error("fault read data wrong");
   chk_txm_fault: assert property ((flash_steady ##0 txm_act) |=> s.r.flt_txm)
      else $error("mask fault missing");
   chk_uv_run: assert property ((flash_steady ##0 p.vrun) |=> s.r.flt_uv)
      else $error("undervoltage fault missing");
endmodule : flc_mode_ctrl

/* File: tb/flc_host_model.sv */
// Host side of the control pins: drives the serial clock line only.
// Assumes a pull-up on the line, so it rests high between frames.
`timescale 1ns/1ps
module flc_host_model (
   input wire logic i_frame,
   input wire logic i_hang,
   output logic o_scl
);
   // 800 ns clock within frames; a powered-off host leaves it low
   initial begin
      o_scl = 1'b1;
      forever begin
         #400;
         if (i_hang) begin
            o_scl = 1'b0;
         end else if (i_frame) begin
            o_scl = ~o_scl;
         end else begin
            o_scl = 1'b1;
         end
      end
   end
endmodule : flc_host_model

/* File: tb/flc_mode_ctrl_tb.sv */
// Self-checking bench for the flash mode controller.
// Assumes the host model drives the clock pin; shortened idle and timeout counts.
`timescale 1ns/1ps
`include "flc_defs.svh"
module flc_mode_ctrl_tb;
   import flc_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_torch = 1'b0;
   logic i_strobe = 1'b0;
   logic i_vlow = 1'b0;
   logic hang = 1'b0;
   logic i_vrun = 1'b0;
   logic i_bal_up = 1'b0;
   logic frame = 1'b0;
   logic scl;
   logic [7:0] o_rdata;
   logic [7:0] s1;
   logic [7:0] s2;
   logic sink_en;
   flc_mode_t mode;
   logic [7:0] d;
   int bad_count = 0;
   int checked = 0;
   always #50 i_ref_clk = ~i_ref_clk;
   flc_host_model i_host (.i_frame(frame), .i_hang(hang), .o_scl(scl));
   flc_mode_ctrl #(.IDLE_CYC(200), .FTO_CYC(50)) i_dut (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl), .i_torch(i_torch),
      .i_strobe(i_strobe), .i_vin_below_low(i_vlow), .i_vin_below_run(i_vrun),
      .i_bal_up(i_bal_up), .i_bal_down(1'b0), .o_sink1_code(s1), .o_sink2_code(s2),
      .o_sink_en(sink_en), .o_mode(mode));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic c, input string m);
      checked++;
      if (c !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
   endtask : rd
   task automatic wm(input flc_mode_t m, input int n);
      int k;
      k = 0;
      while (mode !== m && k < n) begin
         @(posedge i_ref_clk);
         #1;
         k++;
      end
      chk(mode === m, "mode not reached");
   endtask : wm
   task automatic rst();
      @(posedge i_ref_clk);
      i_rst_n <= 1'b0;
      i_torch <= 1'b0;
      i_strobe <= 1'b0;
      i_vlow <= 1'b0;
      hang <= 1'b0;
      i_vrun <= 1'b0;
      i_bal_up <= 1'b0;
      frame <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
   endtask : rst
   task automatic setup(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] fto);
      rst();
      wr(`FLC_ADDR_CUR1, c1);
      wr(`FLC_ADDR_CUR2, c2);
      wr(`FLC_ADDR_FTO, fto);
   endtask : setup
   task automatic t_reset();
      rst();
      #1;
      chk(mode === ST_STANDBY && s1 === 8'h00 && sink_en === 1'b0, "reset outputs");
      rd(`FLC_ADDR_CTRL, d);
      chk(d === 8'h00, "ctrl reset value");
      rd(4'hF, d);
      chk(d === 8'h00, "unmapped read");
      wr(`FLC_ADDR_CUR1, 8'hFF);
      wr(`FLC_ADDR_CTRL, 8'h02);
      repeat (10) @(posedge i_ref_clk);
      #1;
      chk(mode === ST_STANDBY && sink_en === 1'b0, "disabled assist");
      wr(`FLC_ADDR_CTRL, 8'h1C);
      repeat (10) @(posedge i_ref_clk);
      #1;
      chk(mode === ST_STANDBY && sink_en === 1'b0, "torch cfg 11");
      $display("test reset_standby done");
   endtask : t_reset
   task automatic t_torch();
      setup(8'hFF, 8'hC5, 8'h01);
      wr(`FLC_ADDR_CTRL, 8'h08);
      i_torch <= 1'b1;
      wm(ST_TORCH, 10);
      chk(s1 === 8'h7F && s2 === 8'h45, "torch codes");
      i_torch <= 1'b0;
      wm(ST_STANDBY, 10);
      wr(`FLC_ADDR_CTRL, 8'h12);
      wm(ST_ASSIST, 10);
      chk(s1 === 8'h7F && s2 === 8'h45 && sink_en === 1'b1, "assist codes");
      wr(`FLC_ADDR_LOWV, 8'h02);
      i_bal_up <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
      #1;
      chk(s1 > 8'h7F && s1 <= 8'h8B && s2 < 8'h45 && s2 >= 8'h3F, "balance trim");
      frame <= 1'b1;
      repeat (250) @(posedge i_ref_clk);
      #1;
      chk(mode === ST_ASSIST, "shutdown with running clock");
      hang <= 1'b1;
      repeat (150) @(posedge i_ref_clk);
      #1;
      chk(mode === ST_ASSIST, "early idle shutdown");
      wm(ST_STANDBY, 100);
      chk(s1 === 8'h00 && sink_en === 1'b0, "idle current");
      rd(`FLC_ADDR_CUR1, d);
      chk(d === 8'h00, "idle register reset");
      $display("test torch_assist_idle done");
   endtask : t_torch
   task automatic t_ind();
      int n;
      n = 0;
      setup(8'hFF, 8'hC5, 8'h01);
      wr(`FLC_ADDR_PWM, 8'h03);
      wr(`FLC_ADDR_CTRL, 8'h11);
      wm(ST_IND, 10);
      chk(s1 === 8'h3F && s2 === 8'h05, "indicator codes");
      repeat (634) begin
         @(posedge i_ref_clk);
         #1;
         if (sink_en === 1'b1) begin
            n++;
         end
      end
      chk(n >= 150 && n <= 167, "pwm duty 4/16");
      $display("test indicator done");
   endtask : t_ind
   task automatic t_flash();
      realtime t0;
      setup(8'h02, 8'h02, 8'h01);
      wr(`FLC_ADDR_CTRL, 8'h13);
      wm(ST_FLASH, 10);
      t0 = $realtime;
      repeat (90) @(posedge i_ref_clk);
      rd(`FLC_ADDR_ACTUAL, d);
      chk(d !== 8'h00 && d <= 8'h02 && s1 === d, "actual current");
      wm(ST_FL_DONE, 200);
      chk($realtime - t0 >= 5000.0 && $realtime - t0 <= 10500.0, "flash length");
      rd(`FLC_ADDR_FAULT, d);
      chk(d[0] === 1'b1, "timeout fault");
      rd(`FLC_ADDR_FAULT, d);
      chk(d === 8'h00, "fault read clear");
      rd(`FLC_ADDR_MIN, d);
      chk(d !== 8'hFF && d <= 8'h02, "minimum current");
      $display("test flash_immediate done");
   endtask : t_flash
   task automatic t_strobe();
      setup(8'h02, 8'h02, 8'h01);
      wr(`FLC_ADDR_CTRL, 8'h73);
      wm(ST_FL_WAIT, 10);
      repeat (20) @(posedge i_ref_clk);
      #1;
      chk(sink_en === 1'b0, "no current before strobe");
      i_strobe <= 1'b1;
      wm(ST_FLASH, 10);
      i_strobe <= 1'b0;
      wm(ST_FL_WAIT, 10);
      chk(sink_en === 1'b0, "current after strobe low");
      i_strobe <= 1'b1;
      wm(ST_FLASH, 10);
      wm(ST_FL_DONE, 200);
      chk(sink_en === 1'b0, "sinks off at timeout");
      rd(`FLC_ADDR_FAULT, d);
      chk(d[0] === 1'b1, "level strobe timeout fault");
      wr(`FLC_ADDR_CTRL, 8'h33);
      repeat (20) @(posedge i_ref_clk);
      #1;
      chk(mode === ST_FL_WAIT, "high strobe is no edge");
      i_strobe <= 1'b0;
      repeat (10) @(posedge i_ref_clk);
      i_strobe <= 1'b1;
      wm(ST_FLASH, 10);
      $display("test strobe done");
   endtask : t_strobe
   task automatic t_run_drop();
      setup(8'h03, 8'h03, 8'h0B);
      wr(`FLC_ADDR_CTRL, 8'h13);
      wm(ST_FLASH, 10);
      repeat (330) @(posedge i_ref_clk);
      #1;
      chk(s1 === 8'h03, "ramp not complete");
      // Diagnostic flash trips the higher run threshold
      i_vrun <= 1'b1;
      repeat (100) @(posedge i_ref_clk);
      #1;
      chk(s1 === 8'h02 && s2 === 8'h02, "run drop first step");
      repeat (80) @(posedge i_ref_clk);
      #1;
      chk(s1 === 8'h01, "run drop second step");
      i_vrun <= 1'b0;
      wm(ST_FL_DONE, 200);
      rd(`FLC_ADDR_FAULT, d);
      chk(d[1] === 1'b1, "run undervoltage fault");
      rd(`FLC_ADDR_MIN, d);
      chk(d === 8'h01, "minimum after drop");
      wr(`FLC_ADDR_CUR1, d);
      wr(`FLC_ADDR_CUR2, d);
      wr(`FLC_ADDR_CTRL, 8'h13);
      wm(ST_FLASH, 10);
      repeat (200) @(posedge i_ref_clk);
      #1;
      chk(s1 === 8'h01 && s2 === 8'h01, "main flash current");
      $display("test run_drop done");
   endtask : t_run_drop
   task automatic t_reduce(input logic [7:0] ctl, input logic tm, input int fb);
      setup(8'h03, 8'h03, 8'h03);
      wr(`FLC_ADDR_TXM, 8'h01);
      i_torch <= tm;
      i_vlow <= ~tm;
      repeat (6) @(posedge i_ref_clk);
      wr(`FLC_ADDR_CTRL, ctl);
      wm(ST_FLASH, 10);
      repeat (170) @(posedge i_ref_clk);
      #1;
      chk(s1 === 8'h01 && s2 === 8'h01, "reduced flash current");
      rd(`FLC_ADDR_FAULT, d);
      chk(d[fb] === 1'b1, "reduction fault");
      $display("test reduction done");
   endtask : t_reduce
   task automatic t_lowv_off();
      setup(8'h03, 8'h03, 8'h01);
      wr(`FLC_ADDR_LOWV, 8'h01);
      i_vlow <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
      wr(`FLC_ADDR_CTRL, 8'h13);
      wm(ST_FL_DONE, 10);
      repeat (20) @(posedge i_ref_clk);
      #1;
      chk(sink_en === 1'b0 && mode === ST_FL_DONE, "flash suppressed");
      rd(`FLC_ADDR_FAULT, d);
      chk(d[1] === 1'b1, "undervoltage fault");
      $display("test lowv_shutdown done");
   endtask : t_lowv_off
   initial begin
      #3000000;
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      summarize();
   end
   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_torch();
      t_ind();
      t_flash();
      t_strobe();
      t_run_drop();
      t_reduce(8'h17, 1'b1, 2);
      t_reduce(8'h13, 1'b0, 1);
      t_lowv_off();
      summarize();
   end
endmodule : flc_mode_ctrl_tb
